// file: verilog/mpdt_top.sv
// two-set block-transfer engine between local memory and the bus master port
// Function
// RL1: two register sets, one programmable while other runs
// RL2: one eight-word staging buffer, both directions
// RL3: unaligned start and length in both directions
// RL4: software programs addresses, direction and enable first
// RL5: engine arbitrates and finishes without processor help
// RL6: only local register writes start transfers
// RL7: direction bit one moves bus to memory
// RL8: bus-to-memory starts by requesting the bus
// RL9: memory requested once four words buffered
// RL10: full buffer releases filler until four remain
// RL11: memory-to-bus starts by loading memory words
// RL12: interleaved base memory requests bus after one
// RL13: other memory waits for four words first
// RL14: drain fast, refill, release memory when full
// RL15: empty buffer mid-burst ends burst with disconnect
// RL16: after disconnect refill and re-request at threshold
// RL17: fetching stops at count, draining continues
// RL18: completion flags set, interrupts, starts other set
// RL19: abort resets channel, records type, interrupts
// RL20: hardware clears start bit, software zero ignored
// RL21: track remaining words and current addresses
// RL22: byte enables trim partial first and last
`timescale 1ns/1ps
module mpdt_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // register bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // local memory controller
    input wire logic MEM_ILV,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [31:0] MEM_ADDR,
    output logic [3:0] MEM_BE,
    output logic [31:0] MEM_WDATA,
    // bus master side, link clock domain
    input wire logic PCI_CLK,
    input wire logic BUS_GNT,
    input wire logic BUS_ACK,
    input wire logic [1:0] BUS_ABORT,
    input wire logic [31:0] BUS_RDATA,
    output logic BUS_REQ,
    output logic BUS_FRAME,
    output logic BUS_WRITE,
    output logic BUS_MEM,
    output logic BUS_LAST,
    output logic [31:0] BUS_ADDR,
    output logic [3:0] BUS_BE,
    output logic [31:0] BUS_WDATA,
    // processor interrupt
    output logic INT_N
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mpdt_pkg::mpdt_set_s [1:0] sets;
        logic ack;
        logic [31:0] rdata;
        mpdt_pkg::mpdt_state_e st;
        logic act;
        logic dir;
        logic ilv;
        logic inc;
        logic mio;
        logic first;
        logic hold;
        logic dst_own;
        logic disc;
        logic [mpdt_pkg::WORDS_W-1:0] fill_left;
        logic [mpdt_pkg::WORDS_W-1:0] drain_left;
        logic [31:0] mem_addr;
        logic [31:0] bus_addr;
        logic [3:0] be_first;
        logic [3:0] be_last;
        logic [1:0] berr;
        logic [mpdt_pkg::IST_W-1:0] istat;
        logic irq;
        logic pclk1;
        logic pclk2;
        logic pclk3;
        logic gnt1;
        logic gnt2;
        logic ack1;
        logic ack2;
        logic [1:0] abt1;
        logic [1:0] abt2;
        logic [31:0] rd1;
        logic [31:0] rd2;
    } mpdt_top_s;

    localparam int unsigned WORDS_W = mpdt_pkg::WORDS_W;

    mpdt_top_s s;
    mpdt_top_s next_s;
    logic [1:0] rst_q;
    logic rst_b;
    logic run;
    logic full;
    logic empty;
    logic src_req;
    logic dst_req;
    logic mem_x;
    logic bus_x;
    logic push;
    logic pop;
    logic pedge;
    logic go_act;
    logic [mpdt_pkg::CNT_W-1:0] thr;
    logic [mpdt_pkg::CNT_W-1:0] cnt;
    logic [mpdt_pkg::IST_W-1:0] ist_set;
    logic [mpdt_pkg::IST_W-1:0] ist_clr;
    logic nxt;
    logic [31:0] c_act;
    mpdt_pkg::mpdt_word_s din;
    mpdt_pkg::mpdt_word_s head;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_b = rst_q[1];

    mpdt_fifo u_fifo ( // [RL2]
        .clk(CLOCK),
        .rst_b(rst_b),
        .clr(s.st != mpdt_pkg::ST_RUN),
        .push(push),
        .pop(pop),
        .din(din),
        .head(head),
        .count(cnt)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.disc = 1'b0;
        ist_set = '0;
        ist_clr = '0;
        // link inputs cross through two stages before use
        next_s.pclk1 = PCI_CLK;
        next_s.pclk2 = s.pclk1;
        next_s.pclk3 = s.pclk2;
        next_s.gnt1 = BUS_GNT;
        next_s.gnt2 = s.gnt1;
        next_s.ack1 = BUS_ACK;
        next_s.ack2 = s.ack1;
        next_s.abt1 = BUS_ABORT;
        next_s.abt2 = s.abt1;
        next_s.rd1 = BUS_RDATA;
        next_s.rd2 = s.rd1;
        pedge = s.pclk2 & ~s.pclk3;

        // one wait state on every access
        next_s.ack = (AVS_READ | AVS_WRITE) & ~s.ack;
        if (AVS_READ & ~s.ack) begin
            case (AVS_ADDRESS)
                mpdt_pkg::OFS_CTRL1: next_s.rdata = s.sets[0].ctrl;
                mpdt_pkg::OFS_MADDR1: next_s.rdata = s.sets[0].maddr;
                mpdt_pkg::OFS_BADDR1: next_s.rdata = s.sets[0].baddr;
                mpdt_pkg::OFS_CTRL2: next_s.rdata = s.sets[1].ctrl;
                mpdt_pkg::OFS_MADDR2: next_s.rdata = s.sets[1].maddr;
                mpdt_pkg::OFS_BADDR2: next_s.rdata = s.sets[1].baddr;
                mpdt_pkg::OFS_WREM: next_s.rdata = 32'(s.drain_left); // [RL21]
                mpdt_pkg::OFS_CURM: next_s.rdata = s.mem_addr;
                mpdt_pkg::OFS_CURB: next_s.rdata = s.bus_addr;
                mpdt_pkg::OFS_BERR: next_s.rdata = 32'(s.berr);
                mpdt_pkg::OFS_ISTAT: next_s.rdata = 32'(s.istat);
                default: next_s.rdata = mpdt_pkg::ZERO_WORD;
            endcase
        end
        // starting is reachable from this port alone [RL6]
        if (AVS_WRITE & s.ack) begin
            for (int k = 0; k < 2; k++) begin
                if (AVS_ADDRESS == (k == 0 ? mpdt_pkg::OFS_CTRL1 : mpdt_pkg::OFS_CTRL2)) begin
                    next_s.sets[k].ctrl = mpdt_pkg::ctrl_wr(s.sets[k].ctrl, AVS_WRITEDATA, AVS_BYTEENABLE); // [RL1] [RL20]
                end
                if (!s.sets[k].ctrl[mpdt_pkg::B_GO]) begin
                    if (AVS_ADDRESS == (k == 0 ? mpdt_pkg::OFS_MADDR1 : mpdt_pkg::OFS_MADDR2)) begin
                        next_s.sets[k].maddr = mpdt_pkg::merge_be(s.sets[k].maddr, AVS_WRITEDATA, AVS_BYTEENABLE);
                    end
                    if (AVS_ADDRESS == (k == 0 ? mpdt_pkg::OFS_BADDR1 : mpdt_pkg::OFS_BADDR2)) begin
                        next_s.sets[k].baddr = mpdt_pkg::merge_be(s.sets[k].baddr, AVS_WRITEDATA, AVS_BYTEENABLE);
                    end
                end
            end
            if (AVS_ADDRESS == mpdt_pkg::OFS_ISTAT && AVS_BYTEENABLE[0]) begin
                ist_clr = AVS_WRITEDATA[mpdt_pkg::IST_W-1:0];
            end
        end

        // ---- datapath handshakes ----
        c_act = s.sets[s.act].ctrl;
        go_act = c_act[mpdt_pkg::B_GO];
        run = (s.st == mpdt_pkg::ST_RUN) & ~c_act[mpdt_pkg::B_SU];
        full = cnt == mpdt_pkg::FULL_CNT;
        empty = cnt == '0;
        thr = (~s.dir & s.ilv) ? mpdt_pkg::ILV_CNT : mpdt_pkg::HALF_CNT; // [RL12] [RL13] [RL9]
        src_req = run & (s.fill_left != '0) & ~s.hold & ~full; // [RL10] [RL17]
        dst_req = run & s.dst_own & ~empty;
        mem_x = (s.dir ? dst_req : src_req) & MEM_ACK;
        bus_x = (s.dir ? src_req : dst_req) & s.gnt2 & s.ack2 & pedge;
        push = s.dir ? bus_x : mem_x; // [RL8] [RL11]
        pop = s.dir ? mem_x : bus_x; // [RL14]
        din.data = s.dir ? s.rd2 : MEM_RDATA;
        din.be = (s.first ? s.be_first : mpdt_pkg::BE_ALL)
            & ((s.fill_left == WORDS_W'(1)) ? s.be_last : mpdt_pkg::BE_ALL); // [RL22] [RL3]

        nxt = go_act ? s.act : ~s.act; // [RL18]
        case (s.st)
            mpdt_pkg::ST_IDLE: begin
                for (int k = 0; k < 2; k++) begin
                    if (s.sets[k].ctrl[mpdt_pkg::B_DRST]) begin
                        next_s.sets[k].ctrl[mpdt_pkg::B_DRST] = 1'b0;
                        next_s.sets[k].ctrl[mpdt_pkg::B_GO] = 1'b0;
                    end
                end
                if (s.sets[nxt].ctrl[mpdt_pkg::B_GO] & ~s.sets[nxt].ctrl[mpdt_pkg::B_DRST]) begin // [RL5]
                    next_s.act = nxt;
                    next_s.dir = s.sets[nxt].ctrl[mpdt_pkg::B_DIR]; // [RL7]
                    next_s.inc = s.sets[nxt].ctrl[mpdt_pkg::B_INC];
                    next_s.mio = s.sets[nxt].ctrl[mpdt_pkg::B_MIO];
                    next_s.ilv = MEM_ILV;
                    next_s.mem_addr = {s.sets[nxt].maddr[31:2], 2'b00};
                    next_s.bus_addr = {s.sets[nxt].baddr[31:2], 2'b00};
                    next_s.fill_left = mpdt_pkg::word_count(s.sets[nxt].maddr[1:0], s.sets[nxt].ctrl[19:0]);
                    next_s.drain_left = next_s.fill_left;
                    next_s.be_first = mpdt_pkg::BE_ALL << s.sets[nxt].maddr[1:0]; // [RL3]
                    next_s.be_last = mpdt_pkg::last_be(s.sets[nxt].maddr[1:0], s.sets[nxt].ctrl[19:0]);
                    next_s.first = 1'b1;
                    next_s.hold = 1'b0;
                    next_s.dst_own = 1'b0;
                    next_s.st = mpdt_pkg::ST_RUN;
                end
            end
            mpdt_pkg::ST_RUN: begin
                if (push) begin
                    next_s.fill_left = s.fill_left - WORDS_W'(1); // [RL21]
                    next_s.first = 1'b0;
                end
                if (pop) begin
                    next_s.drain_left = s.drain_left - WORDS_W'(1);
                end
                if (mem_x) begin
                    next_s.mem_addr = s.mem_addr + mpdt_pkg::WORD_STEP;
                end
                if (bus_x & s.inc) begin
                    next_s.bus_addr = s.bus_addr + mpdt_pkg::WORD_STEP;
                end
                // a full buffer parks the filler until half drained
                if (full) begin
                    next_s.hold = 1'b1; // [RL10] [RL14]
                end else if (cnt <= mpdt_pkg::HALF_CNT) begin
                    next_s.hold = 1'b0;
                end
                if (s.dst_own & empty & ~push) begin
                    next_s.dst_own = 1'b0;
                    next_s.disc = ~s.dir & (s.drain_left != '0); // [RL15]
                end else if (cnt >= thr || (s.fill_left == '0 && !empty)) begin
                    next_s.dst_own = 1'b1; // [RL16] [RL9]
                end
                if (c_act[mpdt_pkg::B_DRST]) begin
                    next_s.sets[s.act].ctrl[mpdt_pkg::B_DRST] = 1'b0;
                    next_s.sets[s.act].ctrl[mpdt_pkg::B_GO] = 1'b0;
                    next_s.dst_own = 1'b0;
                    next_s.st = mpdt_pkg::ST_IDLE;
                end else if (s.abt2 != 2'b00) begin
                    next_s.berr = s.abt2; // [RL19]
                    next_s.st = mpdt_pkg::ST_ERR;
                end else if (s.drain_left == '0) begin
                    next_s.st = mpdt_pkg::ST_FIN;
                end
            end
            mpdt_pkg::ST_FIN: begin
                next_s.sets[s.act].ctrl[mpdt_pkg::B_GO] = 1'b0; // [RL20]
                ist_set[s.act ? mpdt_pkg::IST_DONE2 : mpdt_pkg::IST_DONE1] = 1'b1; // [RL18]
                next_s.act = ~s.act;
                next_s.dst_own = 1'b0;
                next_s.st = mpdt_pkg::ST_IDLE;
            end
            mpdt_pkg::ST_ERR: begin
                next_s.sets[s.act].ctrl[mpdt_pkg::B_GO] = 1'b0; // [RL19]
                ist_set[mpdt_pkg::IST_BERR] = 1'b1;
                next_s.act = ~s.act;
                next_s.dst_own = 1'b0;
                next_s.st = mpdt_pkg::ST_IDLE;
            end
            default: begin
                next_s.st = mpdt_pkg::ST_IDLE;
            end
        endcase

        // a flag raised in the clearing cycle survives
        next_s.istat = (s.istat & ~ist_clr) | ist_set;
        next_s.irq = (next_s.istat[mpdt_pkg::IST_DONE1] & s.sets[0].ctrl[mpdt_pkg::B_IE])
            | (next_s.istat[mpdt_pkg::IST_DONE2] & s.sets[1].ctrl[mpdt_pkg::B_IE])
            | (next_s.istat[mpdt_pkg::IST_BERR]
            & (s.sets[0].ctrl[mpdt_pkg::B_IE] | s.sets[1].ctrl[mpdt_pkg::B_IE])); // [RL18] [RL19]
    end

    always_ff @(posedge CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign AVS_READDATA = s.rdata;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
    assign MEM_REQ = s.dir ? dst_req : src_req;
    assign MEM_WE = s.dir;
    assign MEM_ADDR = s.mem_addr;
    assign MEM_BE = head.be;
    assign MEM_WDATA = head.data;
    assign BUS_REQ = s.dir ? src_req : dst_req;
    assign BUS_FRAME = BUS_REQ & s.gnt2;
    assign BUS_WRITE = ~s.dir;
    assign BUS_MEM = s.mio;
    assign BUS_LAST = s.disc;
    assign BUS_ADDR = s.bus_addr;
    assign BUS_BE = s.dir ? mpdt_pkg::BE_ALL : head.be;
    assign BUS_WDATA = head.data;
    assign INT_N = ~s.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!rst_b);

    sequence start_s;
        $rose(s.st == mpdt_pkg::ST_RUN);
    endsequence
    sequence finish_s;
        s.st == mpdt_pkg::ST_FIN ##1 s.st == mpdt_pkg::ST_IDLE;
    endsequence

    chk_fifo_bound: assert property (cnt <= mpdt_pkg::FULL_CNT) // [RL2]
        else $error("staging buffer count above eight");
    chk_b2m_first: assert property (start_s and s.dir |-> !MEM_REQ [*4]) // [RL8]
        else $error("memory requested before bus data on bus read");
    chk_m2b_first: assert property (start_s and !s.dir |-> !BUS_REQ [*2]) // [RL11]
        else $error("bus requested before memory data on bus write");
    chk_own_thresh: assert property ($rose(s.dst_own) |->
        ($past(cnt) >= $past(thr) || $past(s.fill_left) == '0)) // [RL9] [RL12] [RL13] [RL16]
        else $error("drain side taken below threshold");
    chk_refill_hold: assert property (s.hold && cnt > mpdt_pkg::HALF_CNT |-> !src_req) // [RL10] [RL14]
        else $error("filler resumed above half full");
    chk_disc_release: assert property (BUS_LAST |-> !BUS_REQ && $past(s.dst_own)) // [RL15]
        else $error("disconnect without releasing bus");
    chk_done_flag: assert property (s.st == mpdt_pkg::ST_FIN && !s.act |->
        finish_s ##0 s.istat[mpdt_pkg::IST_DONE1] && !s.sets[0].ctrl[mpdt_pkg::B_GO]) // [RL18] [RL20]
        else $error("completion of set one not flagged");
    chk_abort_reset: assert property (s.st == mpdt_pkg::ST_RUN && !c_act[mpdt_pkg::B_DRST] && s.abt2 != 2'b00 |=>
        s.st == mpdt_pkg::ST_ERR ##1 (s.st == mpdt_pkg::ST_IDLE && cnt == '0 && s.istat[mpdt_pkg::IST_BERR])) // [RL19]
        else $error("abort did not reset channel");
    chk_go_holds: assert property (s.st == mpdt_pkg::ST_RUN ##1 s.st == mpdt_pkg::ST_RUN |-> go_act) // [RL20]
        else $error("start bit dropped during transfer");
    chk_words_left: assert property (pop && s.st == mpdt_pkg::ST_RUN |=>
        s.drain_left == $past(s.drain_left) - WORDS_W'(1)) // [RL21]
        else $error("remaining count not advanced");
endmodule // mpdt_top

// file: verilog/mpdt_pkg.sv
// shared constants, types and helpers of the memory/bus block-transfer engine
package mpdt_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned DEPTH = 8;
    localparam int unsigned PTR_W = 3;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned WORDS_W = 19;
    localparam logic [CNT_W-1:0] FULL_CNT = 4'h8;
    localparam logic [CNT_W-1:0] HALF_CNT = 4'h4;
    localparam logic [CNT_W-1:0] ILV_CNT = 4'h1;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL1 = 8'h38;
    localparam logic [7:0] OFS_MADDR1 = 8'h3C;
    localparam logic [7:0] OFS_BADDR1 = 8'h40;
    localparam logic [7:0] OFS_CTRL2 = 8'h44;
    localparam logic [7:0] OFS_MADDR2 = 8'h48;
    localparam logic [7:0] OFS_BADDR2 = 8'h4C;
    localparam logic [7:0] OFS_WREM = 8'h64;
    localparam logic [7:0] OFS_CURM = 8'h68;
    localparam logic [7:0] OFS_CURB = 8'h6C;
    localparam logic [7:0] OFS_BERR = 8'h70;
    localparam logic [7:0] OFS_ISTAT = 8'h74;
    // ------------------------------------------------------------
    // control and status word fields
    // ------------------------------------------------------------
    localparam int unsigned B_DRST = 24;
    localparam int unsigned B_MIO = 25;
    localparam int unsigned B_INC = 26;
    localparam int unsigned B_SU = 27;
    localparam int unsigned B_GO = 28;
    localparam int unsigned B_DIR = 29;
    localparam int unsigned B_IE = 30;
    localparam logic [31:0] CTRL_MASK = 32'h7FFF_FFFF;
    localparam logic [31:0] CTRL_LIVE = 32'h0900_0000;
    localparam int unsigned IST_W = 6;
    localparam int unsigned IST_DONE1 = 1;
    localparam int unsigned IST_DONE2 = 2;
    localparam int unsigned IST_BERR = 5;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] be;
    } mpdt_word_s;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] maddr;
        logic [31:0] baddr;
    } mpdt_set_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FIN = 2'b11,
        ST_ERR = 2'b10
    } mpdt_state_e;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_be(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = w[8*i +: 8];
            end
        end
        return r;
    endfunction
    // a running set only lets reset and suspend through
    function automatic logic [31:0] ctrl_wr(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
        logic [31:0] m;
        m = merge_be(o, w, be) & CTRL_MASK;
        return o[B_GO] ? ((o & ~CTRL_LIVE) | (m & CTRL_LIVE)) : m;
    endfunction
    // size 0 means one megabyte
    function automatic logic [WORDS_W-1:0] word_count(input logic [1:0] a, input logic [19:0] size);
        logic [21:0] tot;
        tot = ((size == 20'h0_0000) ? 22'h10_0000 : {2'b00, size}) + {20'h0_0000, a} + 22'h00_0003;
        return tot[20:2];
    endfunction
    function automatic logic [3:0] last_be(input logic [1:0] a, input logic [19:0] size);
        logic [1:0] e;
        e = a + size[1:0];
        return (e == 2'b00) ? BE_ALL : ~(BE_ALL << e);
    endfunction
endpackage

// file: verilog/mpdt_fifo.sv
// eight-word staging buffer shared by both transfer directions
`timescale 1ns/1ps
module mpdt_fifo (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic clr,
    input wire logic push,
    input wire logic pop,
    // data
    input wire mpdt_pkg::mpdt_word_s din,
    output mpdt_pkg::mpdt_word_s head,
    output logic [mpdt_pkg::CNT_W-1:0] count
);
    typedef struct packed {
        mpdt_pkg::mpdt_word_s [mpdt_pkg::DEPTH-1:0] mem;
        logic [mpdt_pkg::PTR_W-1:0] rp;
        logic [mpdt_pkg::PTR_W-1:0] wp;
        logic [mpdt_pkg::CNT_W-1:0] cnt;
    } mpdt_fifo_s;

    localparam int unsigned CNT_W = mpdt_pkg::CNT_W;

    mpdt_fifo_s s;
    mpdt_fifo_s next_s;
    logic do_push;
    logic do_pop;

    always_comb begin
        next_s = s;
        do_push = push & (s.cnt != mpdt_pkg::FULL_CNT);
        do_pop = pop & (s.cnt != '0);
        if (do_push) begin
            next_s.mem[s.wp] = din;
            next_s.wp = s.wp + 1'b1;
        end
        if (do_pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
        if (clr) begin
            next_s.rp = '0;
            next_s.wp = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign head = s.mem[s.rp];
    assign count = s.cnt;
endmodule // mpdt_fifo

// file: verification/mpdt_far_model.sv
// far-side model: local memory controller and bus target
`timescale 1ns/1ps
module mpdt_far_model (
    // clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic rst_b,
    // memory side
    input wire logic mem_req,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [15:0] mem_words,
    // bus target side
    input wire logic bus_req,
    output logic bus_gnt,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    // stall control
    input wire logic slow
);
    logic [3:0] tick;
    // slow mode: one memory word in sixteen clocks, slower than the bus, so memory-to-bus transfers run the buffer dry
    assign mem_ack = mem_req && (!slow || tick == 4'h0);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 4'h0;
            mem_words <= 16'h0000;
            mem_rdata <= 32'h0000_0000;
        end else begin
            tick <= tick + 4'h1;
            mem_words <= mem_words + {15'h0000, mem_ack};
            // data moves every cycle so a stale word never looks fresh
            mem_rdata <= mem_rdata + 32'h0101_0101;
        end
    end
    always @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_gnt <= 1'b0;
            bus_ack <= 1'b0;
            bus_rdata <= 32'h0000_0000;
        end else begin
            bus_gnt <= bus_req;
            bus_ack <= bus_req && (!slow || tick[0]);
            bus_rdata <= ~bus_rdata ^ {16'h0000, mem_words};
        end
    end
endmodule // mpdt_far_model

// file: verification/test_mpdt_top.sv
// self-checking bench of the two-set block-transfer engine
`timescale 1ns/1ps
module test_mpdt_top;
    logic CLOCK = 0, PCI_CLK = 0, RST_B = 0, AVS_READ = 0, AVS_WRITE = 0, MEM_ILV = 0, slow = 0;
    logic [7:0] AVS_ADDRESS = 0;
    logic [3:0] AVS_BYTEENABLE = 0;
    logic [1:0] BUS_ABORT = 0;
    logic [31:0] AVS_WRITEDATA = 0, rnd = 32'h9adc_f72b, q, AVS_READDATA, MEM_RDATA, BUS_RDATA;
    logic AVS_WAITREQUEST, MEM_ACK, MEM_REQ, MEM_WE, BUS_GNT, BUS_ACK, BUS_REQ, BUS_FRAME, BUS_WRITE, INT_N;
    logic [15:0] mem_words, w0;
    int err_count = 0, comparisons = 0;
    always #12.5 CLOCK = !CLOCK;
    always #100 PCI_CLK = !PCI_CLK;
    mpdt_top u_dut (.CLOCK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE, .AVS_WRITEDATA,
        .AVS_READDATA, .AVS_WAITREQUEST, .MEM_ILV, .MEM_ACK, .MEM_RDATA, .MEM_REQ, .MEM_WE, .MEM_ADDR(),
        .MEM_BE(), .MEM_WDATA(), .PCI_CLK, .BUS_GNT, .BUS_ACK, .BUS_ABORT, .BUS_RDATA, .BUS_REQ, .BUS_FRAME,
        .BUS_WRITE, .BUS_MEM(), .BUS_LAST(), .BUS_ADDR(), .BUS_BE(), .BUS_WDATA(), .INT_N);
    mpdt_far_model u_far (.clk(CLOCK), .link_clk(PCI_CLK), .rst_b(RST_B), .mem_req(MEM_REQ), .mem_ack(MEM_ACK),
        .mem_rdata(MEM_RDATA), .mem_words, .bus_req(BUS_REQ), .bus_gnt(BUS_GNT), .bus_ack(BUS_ACK),
        .bus_rdata(BUS_RDATA), .slow);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] nwords(input logic [1:0] a, input logic [19:0] sz);
        return (32'(a) + 32'(sz) + 32'h3) >> 2;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // request held until the edge that sees waitrequest low
    task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(negedge CLOCK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
        @(posedge CLOCK);
        q = AVS_READDATA;
        AVS_WRITE <= 0;
        AVS_READ <= 0;
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic go(input logic [7:0] o, input logic dir, input logic ab);
        logic [19:0] sz;
        rnd = lfsr(rnd);
        sz = ab ? 20'h0_0400 : {14'h0, rnd[5:0]} + 20'h0_000C;
        MEM_ILV <= rnd[8];
        slow <= rnd[9];
        w0 = mem_words;
        avs(1, o + 8'h04, {rnd[31:10], 8'h00, rnd[7:6]}, 4'hF);
        avs(1, o + 8'h08, {rnd[31:10], 8'h00, rnd[7:6]}, 4'hF);
        avs(1, o, {2'b01, dir, 5'b10110, 4'h0, sz}, 4'hF);
        avs(1, o, 32'h0000_0000, 4'hF);
        cmp({31'h0, MEM_WE}, {31'h0, dir});
        cmp({31'h0, BUS_WRITE}, {31'h0, !dir});
        if (ab) begin
            repeat (200) if (BUS_FRAME !== 1'b1) @(negedge CLOCK);
            cmp({31'h0, BUS_FRAME}, 1);
            @(posedge CLOCK);
            BUS_ABORT <= 2'b10;
            repeat (8) @(posedge CLOCK);
            BUS_ABORT <= 2'b00;
        end
        repeat (400) begin
            avs(0, o, 0, 4'hF);
            if (q[28] === 1'b0) break;
        end
        cmp({31'h0, q[28]}, 0);
        if (!ab) begin
            cmp({16'h0, mem_words - w0}, nwords(rnd[7:6], sz));
            avs(0, 8'h68, 0, 4'hF);
            cmp(q, {rnd[31:10], 10'h000} + (nwords(rnd[7:6], sz) << 2));
            avs(0, 8'h6C, 0, 4'hF);
            cmp(q, {rnd[31:10], 10'h000} + (nwords(rnd[7:6], sz) << 2));
        end
        avs(0, 8'h74, 0, 4'hF);
        cmp(q, ab ? 32'h20 : (o == 8'h38 ? 32'h2 : 32'h4));
        cmp({31'h0, INT_N}, 0);
        if (ab) avs(0, 8'h70, 0, 4'hF);
        if (ab) cmp(q, 32'h2);
        avs(1, 8'h74, 32'h0000_00FF, 4'h1);
        @(negedge CLOCK);
        @(negedge CLOCK);
        cmp({31'h0, INT_N}, 1);
        @(posedge CLOCK);
    endtask
    initial begin
        repeat (5) @(posedge CLOCK);
        RST_B <= 1;
        repeat (4) @(posedge CLOCK);
        avs(0, 8'h44, 0, 4'hF);
        cmp(q, 0);
        avs(1, 8'h00, 32'hFFFF_FFFF, 4'hF);
        avs(0, 8'h00, 0, 4'hF);
        cmp(q, 0);
        avs(1, 8'h3C, rnd, 4'hF);
        avs(1, 8'h48, ~rnd, 4'hF);
        avs(0, 8'h3C, 0, 4'hF);
        cmp(q, rnd);
        repeat (8) go(rnd[3] ? 8'h38 : 8'h44, rnd[4], 0);
        go(8'h38, 1, 1);
        tally_and_finish();
    end
endmodule // test_mpdt_top
